// ==== verification/fia_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// stand-in for the processor core: one request at a time, launched off the falling edge
module fia_core_model (
	input wire logic clk,
	input wire logic flash_rvalid,
	input wire logic [7:0] flash_rdata,
	input wire logic access_denied,
	input wire logic cpu_wait,
	input wire logic [7:0] sfr_rdata,
	output logic code_rd,
	output logic xmov_rd,
	output logic xmov_wr,
	output logic [15:0] addr,
	output logic [7:0] wdata,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_addr,
	output logic timed_out
);
	// quiet bus until the bench issues something
	initial begin
		{code_rd, xmov_rd, xmov_wr, sfr_wr, sfr_rd} = 5'h00;
		addr = 16'h0000;
		sfr_addr = 8'h00;
		wdata = 8'h00;
		timed_out = 1'b0;
	end

	// an idle cycle first, so a strobe never falls and rises in one step
	// strobe held over exactly one taking edge; the returning negedge is the answer cycle
	task automatic req(input logic [4:0] k, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		{code_rd, xmov_rd, xmov_wr, sfr_wr, sfr_rd} = k;
		addr = a;
		sfr_addr = a[7:0];
		wdata = d;
		@(negedge clk);
		{code_rd, xmov_rd, xmov_wr, sfr_wr, sfr_rd} = 5'h00;
	endtask

	task automatic sread(input logic [7:0] a, output logic [7:0] q);
		req(5'h01, {8'h00, a}, 8'h00);
		q = sfr_rdata;
	endtask

	// code read when mv is low, data move read otherwise; bounded wait for the data
	task automatic fread(input logic mv, input logic [15:0] a, output logic [7:0] q,
		output logic den);
		logic ok;
		ok = 1'b0;
		den = 1'b0;
		q = 8'h00;
		req(mv ? 5'h08 : 5'h10, a, 8'h00);
		for (int i = 0; i < 4; i++) begin
			den = den | access_denied;
			if (flash_rvalid === 1'b1 && !ok) begin
				q = flash_rdata;
				ok = 1'b1;
			end
			@(negedge clk);
		end
		if (!ok) timed_out = 1'b1;
	endtask

	// counts stall cycles; nothing new is issued until the stall has ended
	task automatic fwrite(input logic [15:0] a, input logic [7:0] d, output int st,
		output logic den);
		st = 0;
		den = 1'b0;
		req(5'h04, a, d);
		for (int i = 0; i < 40; i++) begin
			den = den | access_denied;
			st += (cpu_wait === 1'b1);
			@(negedge clk);
		end
		if (cpu_wait !== 1'b0) timed_out = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== verification/test_flash_in_app_access_guard.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_flash_in_app_access_guard;
	// short program stall so the run stays brief
	localparam int WCYC = 16;
	logic clk = 1'b0;
	logic rst_n, por_n, idata_req, idata_indirect, lock;
	logic [7:0] idata_addr, sfr_rdata, flash_rdata, sfr_addr, wdata;
	logic [7:0] config_low_byte, config_high_byte, irq_enable_one;
	logic [15:0] addr;
	logic code_rd, xmov_rd, xmov_wr, sfr_wr, sfr_rd, timed_out, flash_rvalid, access_denied;
	logic idata_to_sfr, idata_to_ram, idata_bank_reg, idata_bit_area, xram_sel;
	logic cpu_wait, soft_reset, boot_busy, wide_unlock_flag;
	int n_errors = 0;
	int samples_checked = 0;

	fia_guard #(.WRITE_CYCLES(WCYC), .HAS_WRITE_KEY(1'b1)) fia_guard_i (
		.clk, .rst_n, .por_n, .code_rd, .code_addr(addr), .xmov_rd, .xmov_wr,
		.xmov_addr(addr), .xmov_wdata(wdata), .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata(wdata),
		.sfr_rdata, .idata_req, .idata_indirect, .idata_addr, .idata_to_sfr, .idata_to_ram,
		.idata_bank_reg, .idata_bit_area, .flash_rdata, .flash_rvalid, .access_denied,
		.xram_sel, .cpu_wait, .soft_reset, .boot_busy, .config_low_byte, .config_high_byte,
		.wide_unlock_flag, .irq_enable_one
	);
	fia_core_model fia_core_model_i (
		.clk, .flash_rvalid, .flash_rdata, .access_denied, .cpu_wait, .sfr_rdata, .code_rd,
		.xmov_rd, .xmov_wr, .addr, .wdata, .sfr_wr, .sfr_rd, .sfr_addr, .timed_out
	);

	initial forever #2 clk = ~clk;

	// a hung core wait or a runaway run ends at the report
	always @(posedge timed_out) begin
		n_errors++;
		stop_test();
	end
	initial begin
		#400000;
		n_errors++;
		stop_test();
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic sw(input logic [7:0] a, input logic [7:0] d);
		fia_core_model_i.req(5'h02, {8'h00, a}, d);
	endtask

	// power-on and chip reset together, then give the config load time to finish
	task automatic power_up;
		por_n = 1'b0;
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		por_n = 1'b1;
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check("boot_busy", boot_busy, 0);
		check("unlock", wide_unlock_flag, 0);
		check("ien1", irq_enable_one, 8'h00);
	endtask

	task automatic t_regs;
		logic [7:0] q;
		sw(8'h97, 8'h65);
		check("unlock", wide_unlock_flag, 1);
		fia_core_model_i.sread(8'h97, q);
		check("cmd bit0", q[0], 1);
		sw(8'h97, 8'h64);
		check("unlock", wide_unlock_flag, 0);
		fia_core_model_i.sread(8'h97, q);
		check("cmd bit0", q[0], 0);
		sw(8'hA9, 8'hA0);
		fia_core_model_i.sread(8'hA9, q);
		check("ien1", q, 8'hA0);
		fia_core_model_i.sread(8'h90, q);
		check("unmapped", q, 8'h00);
		sw(8'hA9, 8'h00);
		sw(8'h97, 8'h56);
		check("soft reset", soft_reset, 1);
		@(negedge clk);
		check("soft reset", soft_reset, 0);
	endtask

	// one write attempt under given unlock and key, then read back both ways
	task automatic wcase(input logic [15:0] a, input logic [7:0] d, input logic unl,
		input logic [2:0] key, input logic allow, input logic mden);
		logic [7:0] old, q;
		logic den;
		int st;
		fia_core_model_i.fread(1'b1, a, old, den);
		sw(8'h97, unl ? 8'h65 : 8'h00);
		sw(8'hA9, {key, 5'h00});
		fia_core_model_i.fwrite(a, d, st, den);
		check("stall cycles", 16'(st), allow ? 16'(WCYC - 1) : 16'h0000);
		check("write denied", den, !allow);
		fia_core_model_i.fread(1'b1, a, q, den);
		check("move data", q, allow ? d : old);
		check("move denied", den, mden);
		sw(8'h97, 8'h00);
		sw(8'hA9, 8'h00);
		fia_core_model_i.fread(1'b0, a, q, den);
		check("code data", q, allow ? d : old);
		check("code denied", den, (a < 16'h0200) && lock);
	endtask

	task automatic t_boot;
		logic [7:0] q;
		logic den;
		power_up();
		check("cfg low", config_low_byte, 8'hC3);
		sw(8'hF7, 8'h3C);
		check("cfg low", config_low_byte, 8'h3C);
		fia_core_model_i.fread(1'b0, 16'h1FFF, q, den);
		check("cfg high", config_high_byte, q);
	endtask

	task automatic icase(input logic ind, input logic [7:0] a, input logic [3:0] exp);
		@(negedge clk);
		idata_indirect = ind;
		idata_addr = a;
		idata_req = 1'b1;
		@(negedge clk);
		idata_req = 1'b0;
		check("idata", {idata_to_sfr, idata_to_ram, idata_bank_reg, idata_bit_area}, exp);
	endtask

	initial begin
		idata_req = 1'b0;
		idata_indirect = 1'b0;
		idata_addr = 8'h00;
		power_up();
		t_regs();
		lock = config_high_byte[5];
		wcase(16'h1F00, 8'h5A, 1'b0, 3'h5, 1'b1, 1'b0);
		wcase(16'h1F00, 8'hA5, 1'b0, 3'h5, 1'b1, 1'b0);
		wcase(16'h1F00, 8'h33, 1'b1, 3'h4, 1'b0, 1'b0);
		wcase(16'h0300, 8'h11, 1'b0, 3'h5, 1'b0, 1'b1);
		wcase(16'h0300, 8'h22, 1'b1, 3'h5, 1'b1, 1'b0);
		wcase(16'h1FFE, 8'h77, 1'b0, 3'h5, 1'b0, 1'b1);
		wcase(16'h1FFE, 8'hC3, 1'b1, 3'h5, 1'b1, 1'b0);
		wcase(16'h1FFF, 8'h00, 1'b1, 3'h5, 1'b0, 1'b1);
		wcase(16'h0100, 8'h44, 1'b1, 3'h5, !lock, lock);
		t_boot();
		// register banks, bit area, direct versus indirect upper half
		icase(1'b0, 8'h00, 4'h6);
		icase(1'b0, 8'h1F, 4'h6);
		icase(1'b0, 8'h20, 4'h5);
		icase(1'b0, 8'h2F, 4'h5);
		icase(1'b0, 8'h7F, 4'h4);
		icase(1'b0, 8'h80, 4'h8);
		icase(1'b0, 8'hFF, 4'h8);
		icase(1'b1, 8'h80, 4'h4);
		icase(1'b1, 8'hFF, 4'h4);
		fia_core_model_i.req(5'h08, 16'hFF00, 8'h00);
		check("xram sel", xram_sel, 1);
		repeat (3) @(negedge clk);
		fia_core_model_i.req(5'h08, 16'hFEFF, 8'h00);
		check("xram sel", xram_sel, 0);
		repeat (3) @(negedge clk);
		// a code read never reaches external ram
		fia_core_model_i.req(5'h10, 16'hFF00, 8'h00);
		check("xram sel", xram_sel, 0);
		repeat (3) @(negedge clk);
		stop_test();
	end
endmodule
`default_nettype wire

// ==== verilog/fia_consts.svh ====
`ifndef FIA_CONSTS_SVH
`define FIA_CONSTS_SVH
// flash map
`define FIA_FLASH_TOP 16'h1FFF
`define FIA_WRITE_TOP 16'h1FFE
`define FIA_LOCK_END 16'h01FF
`define FIA_ALL_END 16'h1EFF
`define FIA_FREE_END 16'h1FFD
`define FIA_CFG_LO 16'h1FFE
`define FIA_CFG_HI 16'h1FFF
`define FIA_XRAM_BASE 16'hFF00
// special registers
`define FIA_SFR_CMD 8'h97
`define FIA_SFR_IEN1 8'hA9
`define FIA_SFR_CFGL 8'hF7
`define FIA_SFR_BASE 8'h80
// register values and fields
`define FIA_CMD_UNLOCK 8'h65
`define FIA_CMD_SOFTRST 8'h56
`define FIA_KEY_OK 3'h5
`define FIA_KEY_HI 7
`define FIA_KEY_LO 5
`define FIA_LOCK_BIT 5
`define FIA_IEN1_RST 8'h00
`define FIA_CFG_RST 8'hFF
// bank and bit region of internal ram
`define FIA_BANK_END 8'h1F
`define FIA_BIT_BASE 8'h20
`define FIA_BIT_END 8'h2F
// timing
`define FIA_CLK_MHZ 250
`define FIA_WRITE_US 500
`endif

// ==== verilog/fia_flash_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
// flash array: byte wide, registered read, byte program with no erase
module fia_flash_mem #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data
);
	// erased flash reads all ones, so config and lock bits are never unknown
	logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '1};
	// no reset on the array; it models stored contents
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ==== verilog/fia_guard.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fia_consts.svh"
module fia_guard
	import fia_pkg::*;
#(
	parameter int WRITE_CYCLES = `FIA_WRITE_US * `FIA_CLK_MHZ,
	parameter bit HAS_WRITE_KEY = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic por_n,
	// code and data move requests from the core
	input wire logic code_rd,
	input wire logic [15:0] code_addr,
	input wire logic xmov_rd,
	input wire logic xmov_wr,
	input wire logic [15:0] xmov_addr,
	input wire logic [7:0] xmov_wdata,
	// special register port
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// internal data space decode
	input wire logic idata_req,
	input wire logic idata_indirect,
	input wire logic [7:0] idata_addr,
	output logic idata_to_sfr,
	output logic idata_to_ram,
	output logic idata_bank_reg,
	output logic idata_bit_area,
	// results
	output logic [7:0] flash_rdata,
	output logic flash_rvalid,
	output logic access_denied,
	output logic xram_sel,
	output logic cpu_wait,
	output logic soft_reset,
	output logic boot_busy,
	output logic [7:0] config_low_byte,
	output logic [7:0] config_high_byte,
	output logic wide_unlock_flag,
	output logic [7:0] irq_enable_one
);
	// stall counter width; a flash write holds the core for WRITE_CYCLES - 1 cycles
	localparam int CW = $clog2(WRITE_CYCLES + 1);

	fia_state_t st_r, st_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic unlock_r, unlock_nxt;
	logic [7:0] ien1_r, ien1_nxt;
	logic [7:0] cfgl_r, cfgl_nxt;
	logic [7:0] cfgh_r, cfgh_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic deny_r, deny_nxt;
	logic xram_r, xram_nxt;
	logic wait_r, wait_nxt;
	logic srst_r, srst_nxt;
	logic to_sfr_r, to_sfr_nxt;
	logic to_ram_r, to_ram_nxt;
	logic bank_r, bank_nxt;
	logic bitar_r, bitar_nxt;
	logic [12:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic [12:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic pend_rd_r, pend_rd_nxt;
	logic cfgl_load_r;
	logic boot_busy_r, boot_busy_nxt;

	// sector decode of a flash address
	function automatic fia_sector_t sector_of(input logic [15:0] a);
		if (a <= `FIA_LOCK_END) begin
			sector_of = FIA_SEC_LOCK;
		end else if (a <= `FIA_ALL_END) begin
			sector_of = FIA_SEC_ALL;
		end else if (a <= `FIA_FREE_END) begin
			sector_of = FIA_SEC_FREE;
		end else begin
			sector_of = FIA_SEC_CFG;
		end
	endfunction

	// data-move permission for a flash address
	function automatic logic move_ok(input logic [15:0] a, input logic lock, input logic unl);
		case (sector_of(a))
			FIA_SEC_LOCK: move_ok = !lock && unl;
			FIA_SEC_ALL: move_ok = unl;
			FIA_SEC_FREE: move_ok = 1'b1;
			FIA_SEC_CFG: move_ok = (a == `FIA_CFG_LO) && unl;
			default: move_ok = 1'b0;
		endcase
	endfunction

	function automatic logic in_flash(input logic [15:0] a);
		in_flash = (a <= `FIA_FLASH_TOP);
	endfunction

	logic lock_bit;
	logic key_ok;
	logic x_flash;
	logic wr_go;
	logic rd_any;
	logic [15:0] rd_addr;
	assign lock_bit = cfgh_r[`FIA_LOCK_BIT];
	// variants without the key field accept any value
	assign key_ok = !HAS_WRITE_KEY
		|| (ien1_r[`FIA_KEY_HI:`FIA_KEY_LO] == `FIA_KEY_OK);
	assign x_flash = in_flash(xmov_addr);
	assign wr_go = xmov_wr && x_flash && (xmov_addr <= `FIA_WRITE_TOP)
		&& key_ok && move_ok(xmov_addr, lock_bit, unlock_r);
	assign rd_any = code_rd || (xmov_rd && x_flash);
	assign rd_addr = code_rd ? code_addr : xmov_addr;

	// boot reads fetch the configuration word, otherwise serve core reads
	always_comb begin
		mem_raddr = rd_addr[12:0];
		if (st_r == FIA_ST_BOOT) begin
			mem_raddr = 13'(`FIA_CFG_HI);
		end else if (st_r == FIA_ST_LOADH) begin
			mem_raddr = 13'(`FIA_CFG_LO);
		end
		mem_we = (st_r == FIA_ST_IDLE) && wr_go;
		mem_waddr = xmov_addr[12:0];
		mem_wdata = xmov_wdata;
	end

	fia_flash_mem #(.AW(13), .DW(8)) fia_flash_mem_i (
		.clk(clk),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata)
	);

	// sequencer: config load after power-on, then stall while programming
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		cfgh_nxt = cfgh_r;
		cfgl_nxt = cfgl_r;
		wait_nxt = 1'b0;
		case (st_r)
			FIA_ST_BOOT: begin
				st_nxt = FIA_ST_LOADH;
			end
			FIA_ST_LOADH: begin
				cfgh_nxt = mem_rdata;
				st_nxt = FIA_ST_IDLE;
			end
			FIA_ST_IDLE: begin
				if (wr_go) begin
					st_nxt = FIA_ST_PROG;
					cnt_nxt = CW'(WRITE_CYCLES - 1);
					wait_nxt = 1'b1;
				end
			end
			FIA_ST_PROG: begin
				// only the core stalls; back to idle as wait drops, so no request is lost
				if (cnt_r <= CW'(1)) begin
					st_nxt = FIA_ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
					wait_nxt = 1'b1;
				end
			end
			default: st_nxt = FIA_ST_IDLE;
		endcase
		boot_busy_nxt = (st_nxt == FIA_ST_BOOT) || (st_nxt == FIA_ST_LOADH);
		// the low byte arrives one cycle after the high byte
		if (st_r == FIA_ST_IDLE && pend_rd_r == 1'b0 && cfgl_load_r) begin
			cfgl_nxt = mem_rdata;
		end else if (sfr_wr && sfr_addr == `FIA_SFR_CFGL) begin
			cfgl_nxt = sfr_wdata;
		end
	end

	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			cfgl_load_r <= 1'b0;
		end else begin
			cfgl_load_r <= (st_r == FIA_ST_LOADH);
		end
	end

	// configuration registers only follow power-on reset, not other resets
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			st_r <= FIA_ST_BOOT;
			cnt_r <= '0;
			cfgh_r <= `FIA_CFG_RST;
			cfgl_r <= `FIA_CFG_RST;
			wait_r <= 1'b0;
			boot_busy_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			cfgh_r <= cfgh_nxt;
			cfgl_r <= cfgl_nxt;
			wait_r <= wait_nxt;
			boot_busy_r <= boot_busy_nxt;
		end
	end

	// command port and interrupt-enable-one register
	always_comb begin
		unlock_nxt = unlock_r;
		ien1_nxt = ien1_r;
		srst_nxt = 1'b0;
		if (sfr_wr && sfr_addr == `FIA_SFR_CMD) begin
			unlock_nxt = (sfr_wdata == `FIA_CMD_UNLOCK);
			srst_nxt = (sfr_wdata == `FIA_CMD_SOFTRST);
		end
		if (sfr_wr && sfr_addr == `FIA_SFR_IEN1) begin
			ien1_nxt = sfr_wdata;
		end
	end

	// register read data, flash read return, address-space decode
	always_comb begin
		rdata_nxt = rdata_r;
		if (sfr_rd) begin
			case (sfr_addr)
				`FIA_SFR_CMD: rdata_nxt = {7'h00, unlock_r};
				`FIA_SFR_IEN1: rdata_nxt = ien1_r;
				`FIA_SFR_CFGL: rdata_nxt = cfgl_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		pend_rd_nxt = (st_r == FIA_ST_IDLE) && rd_any && !wr_go;
		rvalid_nxt = pend_rd_r;
		// code reads never blocked outside the lock sector
		deny_nxt = (code_rd && sector_of(code_addr) == FIA_SEC_LOCK && lock_bit)
			|| (!code_rd && xmov_rd && x_flash && !move_ok(xmov_addr, lock_bit, unlock_r))
			|| (xmov_wr && x_flash && !wr_go);
		xram_nxt = (xmov_rd || xmov_wr) && (xmov_addr >= `FIA_XRAM_BASE);
		to_sfr_nxt = idata_req && !idata_indirect
			&& (idata_addr >= `FIA_SFR_BASE);
		to_ram_nxt = idata_req && (idata_indirect
			|| idata_addr < `FIA_SFR_BASE);
		bank_nxt = idata_req && (idata_addr <= `FIA_BANK_END) && !to_sfr_nxt;
		bitar_nxt = idata_req && (idata_addr >= `FIA_BIT_BASE)
			&& (idata_addr <= `FIA_BIT_END);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unlock_r <= 1'b0;
			ien1_r <= `FIA_IEN1_RST;
			srst_r <= 1'b0;
			rdata_r <= 8'h00;
			pend_rd_r <= 1'b0;
			rvalid_r <= 1'b0;
			deny_r <= 1'b0;
			xram_r <= 1'b0;
			to_sfr_r <= 1'b0;
			to_ram_r <= 1'b0;
			bank_r <= 1'b0;
			bitar_r <= 1'b0;
		end else begin
			unlock_r <= unlock_nxt;
			ien1_r <= ien1_nxt;
			srst_r <= srst_nxt;
			rdata_r <= rdata_nxt;
			pend_rd_r <= pend_rd_nxt;
			rvalid_r <= rvalid_nxt;
			deny_r <= deny_nxt;
			xram_r <= xram_nxt;
			to_sfr_r <= to_sfr_nxt;
			to_ram_r <= to_ram_nxt;
			bank_r <= bank_nxt;
			bitar_r <= bitar_nxt;
		end
	end

	// flash read data already registered in the memory
	logic [7:0] frd_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frd_r <= 8'h00;
		end else if (pend_rd_r) begin
			frd_r <= mem_rdata;
		end
	end

	assign sfr_rdata = rdata_r;
	assign flash_rdata = frd_r;
	assign flash_rvalid = rvalid_r;
	assign access_denied = deny_r;
	assign xram_sel = xram_r;
	assign cpu_wait = wait_r;
	assign soft_reset = srst_r;
	assign boot_busy = boot_busy_r;
	assign config_low_byte = cfgl_r;
	assign config_high_byte = cfgh_r;
	assign wide_unlock_flag = unlock_r;
	assign irq_enable_one = ien1_r;
	assign idata_to_sfr = to_sfr_r;
	assign idata_to_ram = to_ram_r;
	assign idata_bank_reg = bank_r;
	assign idata_bit_area = bitar_r;

	// assertions
	a_unlock_cmd_set: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_wr && sfr_addr == `FIA_SFR_CMD |=> unlock_r == $past(sfr_wdata == `FIA_CMD_UNLOCK))
		else $error("unlock flag not following command write");
	a_cmd_read_flag: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_rd && sfr_addr == `FIA_SFR_CMD |=> sfr_rdata == {7'h00, $past(unlock_r)})
		else $error("command read does not show unlock flag");
	a_soft_reset_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_wr && sfr_addr == `FIA_SFR_CMD && sfr_wdata == `FIA_CMD_SOFTRST |=> soft_reset)
		else $error("soft reset command missed");
	a_no_key_no_wr: assert property (@(posedge clk) disable iff (!por_n || !rst_n)
		HAS_WRITE_KEY && ien1_r[`FIA_KEY_HI:`FIA_KEY_LO] != `FIA_KEY_OK |-> !mem_we)
		else $error("flash write without key");
	a_high_cfg_locked: assert property (@(posedge clk) disable iff (!por_n)
		mem_we |-> mem_waddr != `FIA_CFG_HI)
		else $error("high config byte written");
	a_lock_sector_wr: assert property (@(posedge clk) disable iff (!por_n)
		mem_we && mem_waddr <= `FIA_LOCK_END |-> !lock_bit && unlock_r)
		else $error("locked sector written");
	a_wr_stalls: assert property (@(posedge clk) disable iff (!por_n)
		mem_we |=> cpu_wait [*8])
		else $error("write did not stall core");
	a_read_no_wait: assert property (@(posedge clk) disable iff (!por_n || !rst_n)
		st_r == FIA_ST_IDLE && code_rd && !wr_go |=> ##1 flash_rvalid && !cpu_wait)
		else $error("flash read delayed");
	a_sfr_direct: assert property (@(posedge clk) disable iff (!rst_n)
		idata_req && !idata_indirect && idata_addr >= `FIA_SFR_BASE
		|=> idata_to_sfr && !idata_to_ram)
		else $error("direct upper address reached ram");
endmodule
`default_nettype wire

// ==== verilog/fia_pkg.sv ====
`default_nettype none
package fia_pkg;
	typedef enum logic [3:0] {
		FIA_SEC_LOCK = 4'h1,
		FIA_SEC_ALL = 4'h2,
		FIA_SEC_FREE = 4'h4,
		FIA_SEC_CFG = 4'h8
	} fia_sector_t;
	typedef enum logic [3:0] {
		FIA_ST_BOOT = 4'h1,
		FIA_ST_LOADH = 4'h2,
		FIA_ST_IDLE = 4'h4,
		FIA_ST_PROG = 4'h8
	} fia_state_t;
endpackage
`default_nettype wire
